// >>> src/pmc_pkg.sv
package pmc_pkg;

  // Register map and reset image
  localparam logic [7:0] POWER_MODE_CONTROL_ADDR  = 8'h2b;
  localparam logic [7:0] POWER_MODE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE      = 8'h00;

  // Arbitrary neutral identity value for this block, not tied to any part
  localparam logic [7:0] PART_IDENTITY_VALUE      = 8'h5c;

  // Timing: the reset quiet period, in ns, and its cycle count at 100 MHz
  localparam int CLK_PERIOD_NS        = 10;
  localparam int RESET_QUIET_TIME_NS  = 1000000;
  localparam int BOOT_CYCLES          = (RESET_QUIET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Output data rate selector codes
  localparam logic [2:0] ODR_800_HZ    = 3'h0;
  localparam logic [2:0] ODR_50_HZ     = 3'h4;
  localparam logic [2:0] ODR_12P5_HZ   = 3'h5;
  localparam logic [2:0] ODR_6P25_HZ   = 3'h6;
  localparam logic [2:0] ODR_1P5625_HZ = 3'h7;

  // Sleep poll rate codes
  localparam logic [1:0] SLEEP_RATE_50_HZ   = 2'h0;
  localparam logic [1:0] SLEEP_RATE_12P5_HZ = 2'h1;
  localparam logic [1:0] SLEEP_RATE_6P25_HZ = 2'h2;
  localparam logic [1:0] SLEEP_RATE_1P56_HZ = 2'h3;

  localparam int OSR_W = 11;

  typedef enum logic [1:0] {
    OSR_NORMAL    = 2'b00,
    OSR_LNLP      = 2'b01,
    OSR_HIGH_RES  = 2'b10,
    OSR_LOW_POWER = 2'b11
  } osr_mode_t;

  // Ratio table, row by data rate code, column by oversampling mode
  localparam logic [10:0] OSR_TABLE [8][4] = '{
    '{11'h002, 11'h002, 11'h002, 11'h002},  // 800 Hz
    '{11'h004, 11'h004, 11'h004, 11'h002},  // 400 Hz
    '{11'h004, 11'h004, 11'h008, 11'h002},  // 200 Hz
    '{11'h004, 11'h004, 11'h010, 11'h002},  // 100 Hz
    '{11'h004, 11'h004, 11'h020, 11'h002},  // 50 Hz
    '{11'h010, 11'h004, 11'h080, 11'h002},  // 12.5 Hz
    '{11'h020, 11'h008, 11'h100, 11'h004},  // 6.25 Hz
    '{11'h080, 11'h020, 11'h400, 11'h010}   // 1.5625 Hz
  };

  typedef struct packed {
    logic      self_test;
    logic      reboot;
    logic      rsvd;
    osr_mode_t sleep_mode;
    logic      auto_sleep_en;
    osr_mode_t wake_mode;
  } power_ctrl_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    SEQ_RUN   = 2'b00,
    SEQ_DRAIN = 2'b01,
    SEQ_BOOT  = 2'b10
  } seq_state_t;

endpackage

// >>> src/boot_timer.sv
`timescale 1ns/1ps
`default_nettype none
module boot_timer #(
  parameter int CYCLES = pmc_pkg::BOOT_CYCLES
) (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic load_i,
  output logic      busy_o,
  output logic      done_o
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LOAD_VALUE = CNT_W'(CYCLES);

  logic [CNT_W-1:0] count_reg;

  // Reload wins over the running count so a held pin keeps the boot going
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      count_reg <= '0;
    else if (load_i)
      count_reg <= LOAD_VALUE;
    else if (count_reg != '0)
      count_reg <= count_reg - CNT_W'(1);
  end

  // Completion pulse in the cycle after the last counted cycle, once the count is zero
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      done_o <= 1'b0;
    else
      done_o <= !load_i && (count_reg == CNT_W'(1));
  end

  assign busy_o = (count_reg != '0);
endmodule
`default_nettype wire

// >>> src/osr_select.sv
`timescale 1ns/1ps
`default_nettype none
module osr_select (
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  input  wire logic              sleep_i,
  input  wire logic [2:0]        odr_sel_i,
  input  wire logic [1:0]        sleep_rate_i,
  input  wire pmc_pkg::osr_mode_t wake_mode_i,
  input  wire pmc_pkg::osr_mode_t sleep_mode_i,
  output logic [pmc_pkg::OSR_W-1:0] oversampling_ratio_o
);
  logic [2:0]         eff_odr;
  pmc_pkg::osr_mode_t eff_mode;

  // In sleep the poll rate overrides the system data rate
  always_comb
  begin
    eff_mode = sleep_i ? sleep_mode_i : wake_mode_i;
    eff_odr  = odr_sel_i;
    if (sleep_i)
    begin
      unique case (sleep_rate_i)
        pmc_pkg::SLEEP_RATE_50_HZ:   eff_odr = pmc_pkg::ODR_50_HZ;
        pmc_pkg::SLEEP_RATE_12P5_HZ: eff_odr = pmc_pkg::ODR_12P5_HZ;
        pmc_pkg::SLEEP_RATE_6P25_HZ: eff_odr = pmc_pkg::ODR_6P25_HZ;
        pmc_pkg::SLEEP_RATE_1P56_HZ: eff_odr = pmc_pkg::ODR_1P5625_HZ;
      endcase
    end
  end

  // Registered ratio, one cycle behind its selectors
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      oversampling_ratio_o <= pmc_pkg::OSR_TABLE[pmc_pkg::ODR_800_HZ][pmc_pkg::OSR_NORMAL];
    else
      oversampling_ratio_o <= pmc_pkg::OSR_TABLE[eff_odr][eff_mode];
  end
endmodule
`default_nettype wire

// >>> src/reboot_sleep_oversample_ctrl.sv
// Overview of operation
// - Reboot request accepted in Standby or Active.
// - Reboot resets registers to default values.
// - Reboot forces Standby first, then boots.
// - High reset pin starts full system reset.
// - Resets also clear the serial interface logic.
// - Reboot bit self-clears when boot completes.
// - Auto-sleep bit: 0 off, 1 on.
// - With auto-sleep, transitions flush FIFO, clear counters.
// - Status survives Sleep/Wake transitions.
// - Wake mode field and rate pick ratio.
// - Sleep mode field picks sleep power scheme.
// - Ratios at 1.5625 Hz: 128/32/1024/16.
// - Remaining rate rows of the ratio table.
`timescale 1ns/1ps
`default_nettype none
module reboot_sleep_oversample_ctrl #(
  parameter int BOOT_CYCLES = pmc_pkg::BOOT_CYCLES
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 resetn_i,
  input  wire pmc_pkg::reg_req_t    reg_req_i,
  output logic                      reg_ack_o,
  output logic [7:0]                reg_rdata_o,
  input  wire logic                 standby_i,
  input  wire logic                 rst_pin_i,
  input  wire logic                 sleep_i,
  input  wire logic [2:0]           odr_sel_i,
  input  wire logic [1:0]           sleep_rate_i,
  output logic                      force_standby_o,
  output logic                      func_reset_o,
  output logic                      comm_reset_o,
  output logic                      boot_busy_o,
  output logic                      self_test_o,
  output logic                      auto_sleep_en_o,
  output pmc_pkg::osr_mode_t        wake_mode_o,
  output pmc_pkg::osr_mode_t        sleep_mode_o,
  output logic                      fifo_flush_o,
  output logic                      count_clear_o,
  output logic [pmc_pkg::OSR_W-1:0] oversampling_ratio_o
);
  pmc_pkg::power_ctrl_t ctrl_reg;
  pmc_pkg::seq_state_t  state_reg;
  pmc_pkg::seq_state_t  state_next;
  logic                 sel_ctrl;
  logic                 wr_ctrl;
  logic                 reboot_req;
  logic                 boot_start;
  logic                 boot_done;
  logic                 timer_busy;
  logic                 sleep_prev_reg;
  logic                 sleep_edge;

  // Address decode for the single control register
  assign sel_ctrl = (reg_req_i.addr == pmc_pkg::POWER_MODE_CONTROL_ADDR);

  // Writes are dropped while a reboot is pending or running so it can't be undone
  assign wr_ctrl = reg_req_i.wr && sel_ctrl && (state_reg == pmc_pkg::SEQ_RUN);

  // A write of one to the reboot bit is a request; zero does nothing
  assign reboot_req = wr_ctrl && reg_req_i.wdata[6];

  // Boot begins right away from Standby, otherwise after Standby is reached
  always_comb
  begin
    state_next = state_reg;
    boot_start = 1'b0;
    if (rst_pin_i)
    begin
      state_next = pmc_pkg::SEQ_BOOT;
      boot_start = 1'b1;
    end
    else
    begin
      unique case (state_reg)
        pmc_pkg::SEQ_RUN:
        begin
          if (reboot_req && standby_i)
          begin
            state_next = pmc_pkg::SEQ_BOOT;
            boot_start = 1'b1;
          end
          else if (reboot_req)
            state_next = pmc_pkg::SEQ_DRAIN;
        end
        pmc_pkg::SEQ_DRAIN:
        begin
          if (standby_i)
          begin
            state_next = pmc_pkg::SEQ_BOOT;
            boot_start = 1'b1;
          end
        end
        pmc_pkg::SEQ_BOOT:
        begin
          if (boot_done)
            state_next = pmc_pkg::SEQ_RUN;
        end
        default:
          state_next = pmc_pkg::SEQ_RUN;
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_reg <= pmc_pkg::SEQ_RUN;
    else
      state_reg <= state_next;
  end

  // Boot duration matches the quiet period the host must honour
  boot_timer #(
    .CYCLES (BOOT_CYCLES)
  ) u_boot_timer (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .load_i    (boot_start),
    .busy_o    (timer_busy),
    .done_o    (boot_done)
  );

  // Control register: software fields, reload on boot, self-clearing reboot bit
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ctrl_reg <= pmc_pkg::power_ctrl_t'(pmc_pkg::POWER_MODE_CONTROL_RESET);
    else if (boot_start || state_reg == pmc_pkg::SEQ_BOOT)
    begin
      ctrl_reg <= pmc_pkg::power_ctrl_t'(pmc_pkg::POWER_MODE_CONTROL_RESET);
      // Only a software request sets the bit; a pin boot leaves it clear
      ctrl_reg.reboot <= (reboot_req || ctrl_reg.reboot) && !rst_pin_i && !boot_done;
    end
    else if (wr_ctrl)
    begin
      ctrl_reg               <= pmc_pkg::power_ctrl_t'(reg_req_i.wdata);
      ctrl_reg.rsvd          <= 1'b0;  // Reserved bit holds no state
      ctrl_reg.reboot        <= reg_req_i.wdata[6];
    end
  end

  // Read path: reboot bit reads one until boot completes, reserved reads zero
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= 8'h00;
      reg_ack_o   <= 1'b0;
    end
    else
    begin
      reg_ack_o <= reg_req_i.rd || reg_req_i.wr;
      if (reg_req_i.rd)
        reg_rdata_o <= sel_ctrl ? 8'(ctrl_reg) : pmc_pkg::UNMAPPED_READ_VALUE;
    end
  end

  // Sleep state history; sampled every cycle so boot leaves no stale edge
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sleep_prev_reg <= 1'b0;
    else
      sleep_prev_reg <= sleep_i;
  end

  assign sleep_edge = (sleep_i != sleep_prev_reg);

  // Flush and counter clear only; status flags elsewhere are left alone
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fifo_flush_o  <= 1'b0;
      count_clear_o <= 1'b0;
    end
    else
    begin
      fifo_flush_o  <= sleep_edge && ctrl_reg.auto_sleep_en;
      count_clear_o <= sleep_edge && ctrl_reg.auto_sleep_en;
    end
  end

  // Reset outputs come straight from state, busy from the timer count; both are combinational decodes of flops
  assign force_standby_o = (state_reg != pmc_pkg::SEQ_RUN);
  assign func_reset_o    = (state_reg == pmc_pkg::SEQ_BOOT);
  assign comm_reset_o    = (state_reg == pmc_pkg::SEQ_BOOT);
  assign boot_busy_o     = timer_busy;

  // Mode fields fan out to the measurement chain
  assign self_test_o     = ctrl_reg.self_test;
  assign auto_sleep_en_o = ctrl_reg.auto_sleep_en;
  assign wake_mode_o     = ctrl_reg.wake_mode;
  assign sleep_mode_o    = ctrl_reg.sleep_mode;

  // Ratio lookup; sleep overrides both rate and mode
  osr_select u_osr_select (
    .clk_sys_i            (clk_sys_i),
    .resetn_i             (resetn_i),
    .sleep_i              (sleep_i),
    .odr_sel_i            (odr_sel_i),
    .sleep_rate_i         (sleep_rate_i),
    .wake_mode_i          (ctrl_reg.wake_mode),
    .sleep_mode_i         (ctrl_reg.sleep_mode),
    .oversampling_ratio_o (oversampling_ratio_o)
  );
endmodule
`default_nettype wire

// >>> tb/pmc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_checker #(
  parameter int BOOT_CYCLES = 8
) (
  input wire logic              clk_sys_i,
  input wire logic              resetn_i,
  input wire pmc_pkg::reg_req_t reg_req_i,
  input wire logic              reg_ack_o,
  input wire logic              standby_i,
  input wire logic              rst_pin_i,
  input wire logic              sleep_i,
  input wire logic              force_standby_o,
  input wire logic              func_reset_o,
  input wire logic              comm_reset_o,
  input wire logic              self_test_o,
  input wire logic              auto_sleep_en_o,
  input wire pmc_pkg::osr_mode_t wake_mode_o,
  input wire logic              fifo_flush_o,
  input wire logic              count_clear_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  int unsigned boot_cnt;
  logic        pin_seen;
  // Length of the current boot in cycles
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      boot_cnt <= 0;
    else if (func_reset_o)
      boot_cnt <= boot_cnt + 1;
    else
      boot_cnt <= 0;
  end
  // Pin resets reload the timer, so their boots are not timed here
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pin_seen <= 1'b0;
    else if (rst_pin_i)
      pin_seen <= 1'b1;
    else if (!func_reset_o)
      pin_seen <= 1'b0;
  end
  sequence s_req;
    reg_req_i.wr || reg_req_i.rd;
  endsequence
  sequence s_sw_boot_end;
    $fell(func_reset_o) && !pin_seen;
  endsequence
  chk_ack_after_req: assert property (s_req |=> reg_ack_o) else $error("no ack");
  chk_ack_no_spur: assert property (!(reg_req_i.wr || reg_req_i.rd) |=> !reg_ack_o)
    else $error("spurious ack");
  chk_comm_with_func: assert property (comm_reset_o == func_reset_o)
    else $error("serial reset apart from boot");
  chk_boot_from_standby: assert property ($rose(func_reset_o) |-> $past(standby_i)
    || $past(rst_pin_i)) else $error("boot outside standby");
  chk_boot_length: assert property (s_sw_boot_end |-> boot_cnt == BOOT_CYCLES + 1)
    else $error("boot length wrong");
  chk_pin_boots: assert property (rst_pin_i |=> func_reset_o && force_standby_o)
    else $error("pin reset ignored");
  chk_flush_on_edge: assert property (auto_sleep_en_o && sleep_i != $past(sleep_i)
    |=> fifo_flush_o && count_clear_o) else $error("no flush on sleep edge");
  chk_no_flush_off: assert property (!auto_sleep_en_o |=> !fifo_flush_o && !count_clear_o)
    else $error("flush with auto-sleep off");
  chk_boot_defaults: assert property ($fell(func_reset_o) |-> !auto_sleep_en_o
    && !self_test_o && wake_mode_o == pmc_pkg::OSR_NORMAL) else $error("fields not reset");
  chk_pending_held: assert property (force_standby_o && !func_reset_o && !standby_i
    |=> force_standby_o) else $error("pending reboot dropped");
endmodule
bind reboot_sleep_oversample_ctrl pmc_checker #(.BOOT_CYCLES(BOOT_CYCLES)) chk (.clk_sys_i,
  .resetn_i, .reg_req_i, .reg_ack_o, .standby_i, .rst_pin_i, .sleep_i, .force_standby_o,
  .func_reset_o, .comm_reset_o, .self_test_o, .auto_sleep_en_o, .wake_mode_o, .fifo_flush_o,
  .count_clear_o);
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        reg_ack_i,
  input  wire logic [7:0]  reg_rdata_i,
  input  wire logic        boot_busy_i,
  output pmc_pkg::reg_req_t req_o
);
  initial req_o = '0;
  // One-cycle strobe; released fields show inverted junk, never stale data
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ack);
    @(negedge clk_sys_i);
    req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk_sys_i);
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    ack = reg_ack_i;
    q = reg_rdata_i;
  endtask
  // Bus held quiet until the quiet period after a reset is over
  task automatic quiet();
    for (int k = 0; k < 2000 && boot_busy_i !== 1'b0; k++)
      @(negedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] A = pmc_pkg::POWER_MODE_CONTROL_ADDR;
  logic clk_sys_i = 0, resetn_i = 0, standby_i = 1, rst_pin_i = 0, sleep_i = 0;
  logic [2:0] odr_sel_i = 0;
  logic [1:0] sleep_rate_i = 0;
  pmc_pkg::reg_req_t reg_req_i;
  pmc_pkg::osr_mode_t wake_mode_o, sleep_mode_o;
  logic reg_ack_o, force_standby_o, func_reset_o, comm_reset_o, boot_busy_o, self_test_o;
  logic auto_sleep_en_o, fifo_flush_o, count_clear_o, ack;
  logic [7:0] reg_rdata_o, q;
  logic [10:0] oversampling_ratio_o;
  int n_fail = 0, n_compared = 0, cyc = 0;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  reboot_sleep_oversample_ctrl #(.BOOT_CYCLES(8)) dut (.clk_sys_i, .resetn_i, .reg_req_i,
    .reg_ack_o, .reg_rdata_o, .standby_i, .rst_pin_i, .sleep_i, .odr_sel_i, .sleep_rate_i,
    .force_standby_o, .func_reset_o, .comm_reset_o, .boot_busy_o, .self_test_o,
    .auto_sleep_en_o, .wake_mode_o, .sleep_mode_o, .fifo_flush_o, .count_clear_o,
    .oversampling_ratio_o);
  host_model host (.clk_sys_i, .reg_ack_i(reg_ack_o), .reg_rdata_i(reg_rdata_o),
    .boot_busy_i(boot_busy_o), .req_o(reg_req_i));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q, ack);
    check(16'(ack), 16'h0001, "write ack");
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.access(1'b0, a, 8'h00, q, ack);
    check({7'h00, ack, q}, {8'h01, e}, "read data");
  endtask
  // Ratio expected for a data rate code and mode
  function automatic logic [10:0] exp_osr(input int o, input int m);
    logic [10:0] t [4];
    case (o)
      7: t = '{11'h080, 11'h020, 11'h400, 11'h010};
      6: t = '{11'h020, 11'h008, 11'h100, 11'h004};
      5: t = '{11'h010, 11'h004, 11'h080, 11'h002};
      4: t = '{11'h004, 11'h004, 11'h020, 11'h002};
      3: t = '{11'h004, 11'h004, 11'h010, 11'h002};
      2: t = '{11'h004, 11'h004, 11'h008, 11'h002};
      1: t = '{11'h004, 11'h004, 11'h004, 11'h002};
      default: t = '{11'h002, 11'h002, 11'h002, 11'h002};
    endcase
    return t[m];
  endfunction
  // Bounded wait for the boot to finish
  task automatic boot_end();
    for (int k = 0; k < 200 && func_reset_o !== 1'b0; k++)
      @(negedge clk_sys_i);
    host.quiet();
  endtask
  task automatic summarize();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
  end
  initial
  begin
    repeat (6) @(negedge clk_sys_i);
    resetn_i = 1;
    check(16'(oversampling_ratio_o), 16'h0002, "ratio reset");
    rd(A, 8'h00);
    rd(8'h2c, 8'h00);
    wr(A, 8'hbf);
    rd(A, 8'h9f);
    check({self_test_o, auto_sleep_en_o, wake_mode_o, sleep_mode_o}, 16'h003f, "fields");
    for (int m = 0; m < 4; m++)
      for (int o = 0; o < 8; o++)
      begin
        wr(A, {3'h0, 2'(m), 1'b0, 2'(m)});
        odr_sel_i = 3'(o);
        repeat (2) @(negedge clk_sys_i);
        check(16'(oversampling_ratio_o), 16'(exp_osr(o, m)), "wake ratio");
      end
    sleep_i = 1;
    @(negedge clk_sys_i);
    check({fifo_flush_o, count_clear_o}, 16'h0000, "flush while off");
    for (int m = 0; m < 4; m++)
      for (int r = 0; r < 4; r++)
      begin
        wr(A, {3'h0, 2'(m), 3'h0});
        sleep_rate_i = 2'(r);
        repeat (2) @(negedge clk_sys_i);
        check(16'(oversampling_ratio_o), 16'(exp_osr(r + 4, m)), "sleep ratio");
      end
    wr(A, 8'h04);
    for (int i = 0; i < 2; i++)
    begin
      sleep_i = 1'(i);
      @(negedge clk_sys_i);
      check({fifo_flush_o, count_clear_o}, 16'h0003, "flush pulse");
      @(negedge clk_sys_i);
      check({fifo_flush_o, count_clear_o}, 16'h0000, "flush length");
    end
    rd(A, 8'h04);
    wr(A, 8'h40);
    check({force_standby_o, func_reset_o, comm_reset_o, boot_busy_o}, 16'h000f, "boot");
    wr(A, 8'h04);
    rd(A, 8'h40);
    boot_end();
    rd(A, 8'h00);
    wr(A, 8'h1c);
    standby_i = 0;
    wr(A, 8'h44);
    repeat (3) @(negedge clk_sys_i);
    check({force_standby_o, func_reset_o}, 16'h0002, "pending");
    standby_i = 1;
    repeat (2) @(negedge clk_sys_i);
    check(16'(func_reset_o), 16'h0001, "boot after standby");
    boot_end();
    rd(A, 8'h00);
    wr(A, 8'h00);
    check(16'(force_standby_o), 16'h0000, "zero write");
    wr(A, 8'h1c);
    rst_pin_i = 1;
    repeat (3) @(negedge clk_sys_i);
    check({func_reset_o, comm_reset_o}, 16'h0003, "pin reset");
    rst_pin_i = 0;
    rd(A, 8'h00);
    boot_end();
    rd(A, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
